// >>> design/xee_events.sv
// external encoder fault event latching and reporting
`timescale 1ns/1ns
module xee_events
    import xee_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // link status from the frame receiver
    input wire logic link_stop,
    input wire logic data_err,
    input wire logic alarm_valid,
    input wire logic [ALARM_BITS-1:0] ext_encoder_alarm_code,
    // phase line fault indications
    input wire logic phase_a_fault,
    input wire logic phase_b_fault,
    input wire logic phase_z_fault,
    // configuration and clear
    input wire logic [7:0] stop_limit,
    input wire logic clear_all,
    // event outputs
    output logic [NUM_EVENTS-1:0] event_flags,
    output logic event_any,
    output logic [31:0] event_code
);
    logic [NUM_EVENTS-1:0] flags_q, flags_d, det;
    logic [7:0] stops_q, stops_d;
    logic [16:0] win_q, win_d;
    logic [31:0] code_q, code_d;
    logic brk_a, brk_b, brk_z, link_det;

    // one filter per phase line so each wire reports on its own
    xee_wire_filter u_fa (
        .clk(clk),
        .resetn(resetn),
        .fault_raw(phase_a_fault),
        .broken(brk_a)
    );

    xee_wire_filter u_fb (
        .clk(clk),
        .resetn(resetn),
        .fault_raw(phase_b_fault),
        .broken(brk_b)
    );

    xee_wire_filter u_fz (
        .clk(clk),
        .resetn(resetn),
        .fault_raw(phase_z_fault),
        .broken(brk_z)
    );

    // stoppages are counted per window; the count restarts each window
    always_comb begin
        win_d = win_q + 17'h00001;
        stops_d = stops_q;
        if (win_q >= 17'(WINDOW_CYCLES - 1)) begin
            win_d = '0;
            stops_d = '0;
        end
        if (link_stop && stops_d != 8'hFF) begin
            stops_d = stops_d + 8'h01;
        end
        link_det = link_stop && (stops_q >= stop_limit);
    end

    always_comb begin
        det = '0;
        det[IDX_LINK] = link_det;
        det[IDX_DATA] = data_err;
        if (alarm_valid) begin
            det[IDX_ALARM] = ext_encoder_alarm_code[0];
            det[IDX_ALARM+5:IDX_ALARM+1] = ext_encoder_alarm_code[5:1];
        end
        det[IDX_PH_A] = brk_a;
        det[IDX_PH_B] = brk_b;
        det[IDX_PH_Z] = brk_z;
        // a detection in the clear cycle wins so no event is lost
        flags_d = (clear_all ? '0 : flags_q) | det;
    end

    // code shows the lowest index of any newly raised flag;
    // a raise in the clear cycle counts as new
    always_comb begin
        code_d = code_q;
        if (clear_all) begin
            code_d = '0;
        end
        for (int i = NUM_EVENTS - 1; i >= 0; i--) begin
            if (det[i] && (clear_all || !flags_q[i])) begin
                code_d = code_of(4'(i));
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stops_q <= '0;
            win_q <= '0;
        end else begin
            stops_q <= stops_d;
            win_q <= win_d;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags_q <= LATCH_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            code_q <= '0;
        end else begin
            code_q <= code_d;
        end
    end

    assign event_flags = flags_q;
    assign event_any = |flags_q;
    assign event_code = code_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    data_latch_a: assert property (data_err |=> event_flags[IDX_DATA])
        else $error("data error not latched");

    data_code_a: assert property (data_err && !link_det
        && !event_flags[IDX_DATA] |=> event_code == EV_DATA_ERR)
        else $error("data error code wrong");

    alarm0_a: assert property (alarm_valid && ext_encoder_alarm_code[0]
        |=> event_flags[IDX_ALARM])
        else $error("alarm bit 0 not latched");

    alarm5_a: assert property (alarm_valid && ext_encoder_alarm_code[5]
        && !event_flags[IDX_ALARM+5] && !data_err && !link_det
        && ext_encoder_alarm_code[4:0] == 5'h00 && !brk_a && !brk_b
        && !brk_z |=> event_code == 32'h08130000)
        else $error("alarm bit 5 code wrong");

    alarm_bits_a: assert property (alarm_valid |=>
        (event_flags[IDX_ALARM+5:IDX_ALARM] & $past(ext_encoder_alarm_code))
        == $past(ext_encoder_alarm_code))
        else $error("alarm bit not latched");

    alarm_gate_a: assert property (!alarm_valid
        && event_flags[IDX_ALARM+5:IDX_ALARM] == 6'h00
        |=> event_flags[IDX_ALARM+5:IDX_ALARM] == 6'h00)
        else $error("alarm latched without valid code");

    link_latch_a: assert property (link_det |=> event_flags[IDX_LINK])
        else $error("link loss not latched");

    link_code_a: assert property (link_det && !event_flags[IDX_LINK]
        |=> event_code == 32'h080C0000)
        else $error("link loss code wrong");

    link_gate_a: assert property (link_stop && stops_q < stop_limit
        && !event_flags[IDX_LINK] && !clear_all
        |=> !event_flags[IDX_LINK])
        else $error("link event raised below threshold");

    stop_count_a: assert property (link_stop && stops_q != 8'hFF
        && win_q != 17'(WINDOW_CYCLES - 1)
        |=> stops_q == $past(stops_q) + 8'h01)
        else $error("stoppage not counted");

    // a break needs the full filter span; one cycle less never latches
    sequence phase_a_held;
        phase_a_fault [*8] ##1 phase_a_fault [*8];
    endsequence

    phase_a_a: assert property (phase_a_held |=> ##1
        event_flags[IDX_PH_A])
        else $error("phase A break not latched");

    sequence phase_z_short;
        !phase_z_fault ##1 phase_z_fault [*8] ##1 phase_z_fault [*7]
        ##1 !phase_z_fault;
    endsequence

    short_z_a: assert property (phase_z_short ##0
        !event_flags[IDX_PH_Z] |=> !event_flags[IDX_PH_Z])
        else $error("short phase Z fault latched");

    phase_z_a: assert property (brk_z |=> event_flags[IDX_PH_Z])
        else $error("phase Z break not latched");

    phase_z_code_a: assert property (brk_z && !event_flags[IDX_PH_Z]
        && det[IDX_PH_Z-1:0] == 10'h000 |=> event_code == EV_PHASE_Z)
        else $error("phase Z code wrong");

    phase_b_a: assert property (brk_b |=> event_flags[IDX_PH_B])
        else $error("phase B break not latched");

    hold_flag_a: assert property (event_flags[IDX_PH_B] && !clear_all
        |=> event_flags[IDX_PH_B])
        else $error("flag dropped without clear");

    flags_sticky_a: assert property (!clear_all |=>
        (event_flags & $past(event_flags)) == $past(event_flags))
        else $error("a flag fell while no clear was given");

    any_flag_a: assert property (event_code != 32'h00000000
        |-> event_any)
        else $error("code shown with no flag raised");

    clear_a: assert property (clear_all && det == '0
        |=> event_flags == '0)
        else $error("clear did not empty flags");

    clear_code_a: assert property (clear_all && det == '0
        |=> event_code == 32'h00000000)
        else $error("clear did not zero the code");
endmodule

// >>> design/xee_pkg.sv
// constants and event codes for the external encoder fault event block
// What this block does
// - link stoppages over threshold raise 080C0000
// - received data integrity failure raises 080D0000
// - alarm code bit 0 raises 080E0000
// - alarm bits 1..5 raise 080F0000..08130000
// - broken phase A, B, Z wiring raise events
package xee_pkg;
    localparam int NUM_EVENTS = 11;
    localparam int ALARM_BITS = 6;
    localparam logic [31:0] EV_LINK_LOST = 32'h080C0000;
    localparam logic [31:0] EV_DATA_ERR = 32'h080D0000;
    localparam logic [31:0] EV_ALARM_BASE = 32'h080E0000;
    localparam logic [31:0] EV_CODE_STEP = 32'h00010000;
    localparam logic [31:0] EV_PHASE_A = 32'h08140000;
    localparam logic [31:0] EV_PHASE_B = 32'h08150000;
    localparam logic [31:0] EV_PHASE_Z = 32'h08160000;
    // event index positions
    localparam int IDX_LINK = 0;
    localparam int IDX_DATA = 1;
    localparam int IDX_ALARM = 2;
    localparam int IDX_PH_A = 8;
    localparam int IDX_PH_B = 9;
    localparam int IDX_PH_Z = 10;
    localparam logic [3:0] IDX_NONE = 4'hF;
    // stoppage counting window and broken wire filter
    localparam int WINDOW_NS = 1000000;
    localparam int CLK_NS = 8;
    localparam int WINDOW_CYCLES = WINDOW_NS / CLK_NS;
    localparam int WIRE_FILT_CYCLES = 16;
    localparam logic [7:0] STOP_LIMIT_RESET = 8'h03;
    localparam logic [NUM_EVENTS-1:0] LATCH_RESET = '0;

    function automatic logic [31:0] code_of(input logic [3:0] idx);
        logic [31:0] c;
        c = EV_LINK_LOST;
        case (idx)
            4'h0: c = EV_LINK_LOST;
            4'h1: c = EV_DATA_ERR;
            4'h8: c = EV_PHASE_A;
            4'h9: c = EV_PHASE_B;
            4'hA: c = EV_PHASE_Z;
            default: c = EV_ALARM_BASE
                + EV_CODE_STEP * 32'(idx - 4'h2);
        endcase
        return c;
    endfunction
endpackage

// >>> design/xee_wire_filter.sv
// per-phase broken wiring detector with a stable-level filter
`timescale 1ns/1ns
module xee_wire_filter
    import xee_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // phase wire health (high means line fault seen)
    input wire logic fault_raw,
    output logic broken
);
    logic [4:0] cnt_q, cnt_d;
    logic broken_q, broken_d;

    // glitches shorter than the filter never flag a break
    always_comb begin
        cnt_d = '0;
        broken_d = broken_q;
        if (fault_raw) begin
            if (cnt_q < 5'(WIRE_FILT_CYCLES)) begin
                cnt_d = cnt_q + 5'h01;
            end else begin
                cnt_d = cnt_q;
            end
        end
        broken_d = fault_raw && (cnt_q >= 5'(WIRE_FILT_CYCLES - 1));
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
            broken_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            broken_q <= broken_d;
        end
    end

    assign broken = broken_q;
endmodule

// >>> tb/xee_enc_model.sv
// encoder side model driving the link and phase lines
`timescale 1ns/1ns
module xee_enc_model (
    // clock
    input wire logic clk,
    // link and phase lines
    output logic link_stop,
    output logic data_err,
    output logic alarm_valid,
    output logic [5:0] alarm,
    output logic [2:0] ph
);
    initial {link_stop, data_err, alarm_valid, alarm, ph} = '0;
    // one frame; pulses last one cycle only
    task automatic frame(input logic s, e, v, input logic [5:0] a);
        @(posedge clk) #1;
        {link_stop, data_err, alarm_valid, alarm} = {s, e, v, a};
        @(posedge clk) #1;
        {link_stop, data_err, alarm_valid} = '0;
        // code no longer valid, so stop showing the old value
        alarm = ~a;
    endtask
    task automatic wire_fault(input logic [2:0] m, input int n);
        @(posedge clk) #1 ph = m;
        repeat (n) @(posedge clk);
        #1 ph = '0;
    endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the fault event block
`timescale 1ns/1ns
module tb_top;
    import xee_pkg::*;
    logic clk, resetn, clear_all, link_stop, data_err, alarm_valid, event_any;
    logic [7:0] stop_limit;
    logic [5:0] alarm;
    logic [2:0] ph;
    logic [NUM_EVENTS-1:0] event_flags;
    logic [31:0] event_code, seed;
    int miscompares, samples_checked;
    xee_enc_model enc (.clk(clk), .link_stop(link_stop), .data_err(data_err),
        .alarm_valid(alarm_valid), .alarm(alarm), .ph(ph));
    xee_events dut (.clk(clk), .resetn(resetn), .link_stop(link_stop),
        .data_err(data_err), .alarm_valid(alarm_valid),
        .ext_encoder_alarm_code(alarm), .phase_a_fault(ph[0]),
        .phase_b_fault(ph[1]), .phase_z_fault(ph[2]),
        .stop_limit(stop_limit), .clear_all(clear_all),
        .event_flags(event_flags), .event_any(event_any),
        .event_code(event_code));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    // codes run consecutively with the flag index
    function automatic logic [31:0] ev(input int i);
        return 32'h080C0000 + 32'(i) * 32'h00010000;
    endfunction
    // several at once: code names the lowest index
    function automatic logic [31:0] low(input logic [10:0] f);
        for (int i = 0; i < 11; i++)
            if (f[i]) return ev(i);
        return 32'h00000000;
    endfunction
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic look(string n, logic [10:0] f, logic [31:0] c);
        chk({n, " flags"}, 32'(f), 32'(event_flags));
        chk({n, " code"}, c, event_code);
        chk({n, " any"}, 32'(|f), 32'(event_any));
        $display("test %s done", n);
    endtask
    task automatic clr;
        @(posedge clk) #1 clear_all = 1'b1;
        @(posedge clk) #1 clear_all = 1'b0;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #160000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        {resetn, clear_all} = 2'h0;
        stop_limit = 8'h02;
        seed = 32'hE721;
        repeat (20) @(posedge clk);
        #1 resetn = 1'b1;
        look("reset", 11'h000, 32'h0);
        enc.frame(1'b0, 1'b1, 1'b0, 6'h3F);
        look("data", 11'h002, EV_DATA_ERR);
        // a detection in the clear cycle must survive the clear
        fork
            enc.frame(1'b0, 1'b1, 1'b0, 6'h00);
            clr();
        join
        look("setwins", 11'h002, EV_DATA_ERR);
        clr();
        look("clear", 11'h000, 32'h0);
        for (int i = 0; i < 6; i++) begin
            enc.frame(1'b0, 1'b0, 1'b1, 6'h01 << i);
            look("alarm", 11'h004 << i, ev(i + 2));
            clr();
        end
        repeat (20) begin
            seed = xs(seed);
            enc.frame(1'b0, seed[6], 1'b1, seed[5:0]);
            look("mixed", 11'({seed[5:0], seed[6], 1'b0}),
                low(11'({seed[5:0], seed[6], 1'b0})));
            clr();
        end
        for (int p = 0; p < 3; p++) begin
            enc.wire_fault(3'h1 << p, 15);
            repeat (3) @(posedge clk);
            #1 look("short", 11'h000, 32'h0);
            enc.wire_fault(3'h1 << p, 16);
            repeat (2) @(posedge clk);
            #1 look("phase", 11'h100 << p, ev(8 + p));
            clr();
        end
        repeat (2) enc.frame(1'b1, 1'b0, 1'b0, 6'h00);
        look("stops", 11'h000, 32'h0);
        enc.frame(1'b1, 1'b0, 1'b0, 6'h00);
        look("lost", 11'h001, EV_LINK_LOST);
        // a reset in mid-run empties the flags and the stoppage count
        @(posedge clk) #1 resetn = 1'b0;
        repeat (2) @(posedge clk);
        #1 resetn = 1'b1;
        look("rereset", 11'h000, 32'h0);
        enc.frame(1'b1, 1'b0, 1'b0, 6'h00);
        look("recount", 11'h000, 32'h0);
        stop_limit = 8'h01;
        enc.frame(1'b1, 1'b0, 1'b0, 6'h00);
        look("limit", 11'h001, EV_LINK_LOST);
        report_and_stop();
    end
endmodule
